// ==== core/dps_supervisor.sv ====
// drive protection supervisor: stall control, over-torque, thermal, faults
module dps_supervisor #(
  parameter longint TENTH_CYCLES = dps_pkg::TENTH_SEC_CYCLES,
  parameter bit HIGH_VOLT_CLASS = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ramp_accel,
  input wire logic ramp_decel,
  input wire logic ramp_steady,
  input wire logic [dps_pkg::VOLT_W-1:0] dc_bus_voltage,
  input wire logic [dps_pkg::CUR_W-1:0] output_current_pct,
  input wire logic [dps_pkg::VOLT_W-1:0] ov_stall_level,
  input wire logic [dps_pkg::PCT_W-1:0] accel_stall_pct,
  input wire logic [dps_pkg::PCT_W-1:0] run_stall_pct,
  input wire logic [2:0] over_torque_mode,
  input wire logic [dps_pkg::PCT_W-1:0] over_torque_pct,
  input wire logic [dps_pkg::TIME_W-1:0] over_torque_tenths,
  input wire logic [1:0] thermal_select,
  input wire logic [dps_pkg::TIME_W-1:0] thermal_char_sec,
  input wire logic [7:0] mfo_function,
  input wire logic fault_event,
  input wire logic [dps_pkg::CODE_W-1:0] fault_code,
  input wire logic reset_cmd,
  output logic freq_hold,
  output logic freq_lower,
  output logic over_torque_warning,
  output logic over_torque_stop,
  output logic thermal_overload_trip,
  output logic drive_tripped,
  output logic mfo_out,
  output logic [dps_pkg::CODE_W-1:0] fault_rec_0,
  output logic [dps_pkg::CODE_W-1:0] fault_rec_1,
  output logic [dps_pkg::CODE_W-1:0] fault_rec_2,
  output logic [dps_pkg::CODE_W-1:0] fault_rec_3,
  output logic [dps_pkg::CODE_W-1:0] fault_rec_4
);
  localparam int TICK_W = $clog2(TENTH_CYCLES + 1);

  // the tick counter needs a period of two cycles at least
  if (TENTH_CYCLES < 2) begin : g_bad_divider
    $error("tenth-second divider needs at least two cycles");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0] rst_sync;
    logic rst_level;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [dps_pkg::SEC_W-1:0] sec_cnt;
    logic [dps_pkg::TIME_W:0] ot_cnt;
    logic [dps_pkg::ACC_W-1:0] heat;
    logic hold;
    logic lower;
    logic ot_warn;
    logic ot_stop;
    logic th_trip;
    logic mfo;
    dps_pkg::dps_state_e state;
  } dps_sup_s;

  dps_sup_s st_reg;
  dps_sup_s st_next;
  dps_hist_if hist ();

  // ****************************************
  // setting decode
  // ****************************************
  logic [dps_pkg::VOLT_W-1:0] ov_lvl;
  logic ov_en;
  logic acc_en;
  logic run_en;
  logic ot_window;
  logic ot_over;
  logic [dps_pkg::CUR_W-1:0] heat_base;
  logic [dps_pkg::ACC_W-1:0] cur_sq;
  logic [dps_pkg::ACC_W-1:0] base_sq;
  logic [dps_pkg::ACC_W-1:0] trip_limit;
  logic rst_rise;
  logic new_fault;
  logic [dps_pkg::CODE_W-1:0] new_code;

  always_comb begin
    ov_en = (ov_stall_level != '0);
    ov_lvl = ov_stall_level;
    // out-of-class settings are pulled into the class range
    if (HIGH_VOLT_CLASS) begin
      if (ov_lvl < dps_pkg::OV_MIN_HIGH_CLASS) ov_lvl = dps_pkg::OV_MIN_HIGH_CLASS;
      if (ov_lvl > dps_pkg::OV_MAX_HIGH_CLASS) ov_lvl = dps_pkg::OV_MAX_HIGH_CLASS;
    end else begin
      if (ov_lvl < dps_pkg::OV_MIN_LOW_CLASS) ov_lvl = dps_pkg::OV_MIN_LOW_CLASS;
      if (ov_lvl > dps_pkg::OV_MAX_LOW_CLASS) ov_lvl = dps_pkg::OV_MAX_LOW_CLASS;
    end
    acc_en = (accel_stall_pct != '0);
    run_en = (run_stall_pct != '0);
    // levels compare straight against percent-of-rated current
    ot_over = output_current_pct > {2'h0, over_torque_pct};
    case (over_torque_mode)
      dps_pkg::OT_CONST_RUN, dps_pkg::OT_CONST_STOP: ot_window = ramp_steady;
      dps_pkg::OT_ACC_RUN, dps_pkg::OT_ACC_STOP: ot_window = ramp_accel;
      default: ot_window = 1'b0;
    endcase
    // self-cooled motors lose margin, so they heat from a lower level
    heat_base = (thermal_select == dps_pkg::TH_STD) ? dps_pkg::STD_MOTOR_PCT
                                                    : dps_pkg::RATED_PCT;
    cur_sq = dps_pkg::ACC_W'(output_current_pct) * dps_pkg::ACC_W'(output_current_pct);
    base_sq = dps_pkg::ACC_W'(heat_base) * dps_pkg::ACC_W'(heat_base);
    trip_limit = dps_pkg::ACC_W'(thermal_char_sec) * dps_pkg::TRIP_SQ_MARGIN;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    new_fault = 1'b0;
    new_code = dps_pkg::FC_NONE;
    // operator pin: change accepted once stages two and three agree
    st_next.rst_sync = {st_reg.rst_sync[1:0], reset_cmd};
    if (st_reg.rst_sync[1] == st_reg.rst_sync[2]) st_next.rst_level = st_reg.rst_sync[2];
    rst_rise = st_next.rst_level & ~st_reg.rst_level;

    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == TICK_W'(TENTH_CYCLES - 1)) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end

    // stall prevention
    st_next.hold = (ramp_decel & ov_en & (dc_bus_voltage > ov_lvl))
                 | (ramp_accel & acc_en & (output_current_pct > {2'h0, accel_stall_pct}));
    st_next.lower = ramp_steady & run_en & (output_current_pct > {2'h0, run_stall_pct});

    // over-torque persistence, counted in tenths of a second
    // the tick phase is free-running: one tick more than the setting
    // keeps the warning from coming before the full detection time
    if (!(ot_window & ot_over)) begin
      st_next.ot_cnt = '0;
      st_next.ot_warn = 1'b0;
    end else if (st_reg.tick && !st_reg.ot_warn) begin
      st_next.ot_cnt = st_reg.ot_cnt + 1'b1;
      if (st_next.ot_cnt > {1'b0, over_torque_tenths} && over_torque_tenths != '0) begin
        st_next.ot_warn = 1'b1;
      end
    end
    st_next.mfo = st_next.ot_warn & (mfo_function == dps_pkg::MFO_OVER_TORQUE);

    // i2t heating, integrated once per second
    if (st_reg.tick) begin
      st_next.sec_cnt = (st_reg.sec_cnt == dps_pkg::TENTHS_PER_SEC - 1'b1) ? '0
                        : st_reg.sec_cnt + 1'b1;
    end
    if (thermal_select == dps_pkg::TH_OFF) begin
      st_next.heat = '0;
    end else if (st_reg.tick && st_reg.sec_cnt == dps_pkg::TENTHS_PER_SEC - 1'b1) begin
      if (cur_sq > base_sq) st_next.heat = st_reg.heat + (cur_sq - base_sq);
      else if (st_reg.heat > (base_sq - cur_sq)) st_next.heat = st_reg.heat - (base_sq - cur_sq);
      else st_next.heat = '0;
    end

    // fault capture: own trips outrank an external report in the same cycle
    if (thermal_select != dps_pkg::TH_OFF && st_reg.heat >= trip_limit && !st_reg.th_trip) begin
      st_next.th_trip = 1'b1;
      new_fault = 1'b1;
      new_code = dps_pkg::FC_THERMAL;
    end else if (st_next.ot_warn && !st_reg.ot_warn && !st_reg.ot_stop &&
                 (over_torque_mode == dps_pkg::OT_CONST_STOP ||
                  over_torque_mode == dps_pkg::OT_ACC_STOP)) begin
      st_next.ot_stop = 1'b1;
      new_fault = 1'b1;
      new_code = dps_pkg::FC_OVER_TORQUE;
    end else if (fault_event && fault_code != dps_pkg::FC_NONE && fault_code <= dps_pkg::FC_MAX) begin
      new_fault = 1'b1;
      new_code = fault_code;
    end

    case (st_reg.state)
      dps_pkg::ST_RUN: begin
        if (new_fault) st_next.state = dps_pkg::ST_TRIP;
      end
      dps_pkg::ST_TRIP: begin
        // a fault landing with the reset keeps the drive tripped
        if (rst_rise && !new_fault) begin
          st_next.state = dps_pkg::ST_RUN;
          st_next.ot_stop = 1'b0;
          st_next.th_trip = 1'b0;
          st_next.heat = '0;
        end
      end
      default: st_next.state = dps_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{rst_sync: '0, rst_level: 1'b0, tick_cnt: '0, tick: 1'b0, sec_cnt: '0,
                 ot_cnt: '0, heat: '0, hold: 1'b0, lower: 1'b0, ot_warn: 1'b0,
                 ot_stop: 1'b0, th_trip: 1'b0, mfo: 1'b0, state: dps_pkg::ST_RUN};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // fault history
  // ****************************************
  assign hist.push = new_fault;
  assign hist.code = new_code;

  // the store registers its records, so the record pins come from flops
  dps_fault_hist u_hist (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hist(hist)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign freq_hold = st_reg.hold;
  assign freq_lower = st_reg.lower;
  assign over_torque_warning = st_reg.ot_warn;
  assign over_torque_stop = st_reg.ot_stop;
  assign thermal_overload_trip = st_reg.th_trip;
  assign drive_tripped = st_reg.state[1]; // one-hot trip bit
  assign mfo_out = st_reg.mfo;
  assign fault_rec_0 = hist.rec[0];
  assign fault_rec_1 = hist.rec[1];
  assign fault_rec_2 = hist.rec[2];
  assign fault_rec_3 = hist.rec[3];
  assign fault_rec_4 = hist.rec[4];

  // ****************************************
  // checks
  // ****************************************
  default clocking dps_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ov_stall_hold_a: assert property (
    ramp_decel && ov_stall_level != '0 && dc_bus_voltage > ov_lvl |=> freq_hold)
    else $error("over-voltage in deceleration did not hold frequency");

  ov_zero_off_a: assert property (
    ov_stall_level == '0 && !ramp_accel |=> !freq_hold)
    else $error("zero voltage threshold still held frequency");

  accel_stall_hold_a: assert property (
    ramp_accel && accel_stall_pct != '0 && output_current_pct > {2'h0, accel_stall_pct}
    |=> freq_hold)
    else $error("acceleration over-current did not hold frequency");

  run_stall_lower_a: assert property (
    freq_lower |-> $past(ramp_steady && run_stall_pct != '0 &&
                         output_current_pct > {2'h0, run_stall_pct}))
    else $error("frequency lowered without running over-current");

  torque_cause_a: assert property (
    $rose(over_torque_warning) |-> $past(ot_over && ot_window) && $past(st_reg.tick))
    else $error("torque warning rose without a timed over-level");

  torque_time_a: assert property (
    $rose(over_torque_warning)
    |-> $past(st_reg.ot_cnt) + 1'b1 > {1'b0, $past(over_torque_tenths)})
    else $error("torque warning before detection time");

  torque_off_a: assert property (
    over_torque_mode == dps_pkg::OT_OFF ##1 over_torque_mode == dps_pkg::OT_OFF
    |-> !over_torque_warning)
    else $error("torque warning with detection disabled");

  torque_stop_a: assert property (
    $rose(over_torque_stop) |-> $past(over_torque_mode == dps_pkg::OT_ACC_STOP ||
                                      over_torque_mode == dps_pkg::OT_CONST_STOP))
    else $error("torque stop in a keep-running mode");

  mfo_follow_a: assert property (
    mfo_out == (over_torque_warning && $past(mfo_function) == dps_pkg::MFO_OVER_TORQUE))
    else $error("output terminal disagrees with torque warning");

  thermal_off_a: assert property (
    thermal_select == dps_pkg::TH_OFF |=> st_reg.heat == '0)
    else $error("thermal model integrated while disabled");

  trip_clear_a: assert property (
    drive_tripped && rst_rise && !new_fault |=> !drive_tripped && !thermal_overload_trip)
    else $error("reset command did not clear the trip");

  trip_log_a: assert property (
    !drive_tripped && new_fault |=> drive_tripped && fault_rec_0 == $past(new_code))
    else $error("logged fault did not trip and record");

  // releases, disabled settings, the sticky torque stop and the thermal trip level
  ov_release_a: assert property (
    !ramp_accel && dc_bus_voltage <= ov_lvl |=> !freq_hold)
    else $error("frequency held with bus voltage below threshold");

  accel_zero_off_a: assert property (
    accel_stall_pct == '0 && !ramp_decel |=> !freq_hold)
    else $error("zero acceleration level still held frequency");

  run_zero_off_a: assert property (
    run_stall_pct == '0 |=> !freq_lower)
    else $error("zero running level still lowered frequency");

  torque_release_a: assert property (
    !(ot_window && ot_over) |=> !over_torque_warning)
    else $error("torque warning outlived the over-level");

  stop_sticky_a: assert property (
    over_torque_stop && !rst_rise |=> over_torque_stop)
    else $error("torque stop dropped without a reset command");

  thermal_trip_a: assert property (
    $rose(thermal_overload_trip) |-> $past(st_reg.heat >= trip_limit))
    else $error("thermal trip before the heat limit");
endmodule : dps_supervisor

// ==== core/dps_pkg.sv ====
// shared widths, codes and timing for the drive protection supervisor
package dps_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int VOLT_W = 14;
  localparam int CUR_W = 10;
  localparam int PCT_W = 8;
  localparam int TIME_W = 10;
  localparam int CODE_W = 6;
  localparam int HIST_DEPTH = 5;
  localparam int ACC_W = 32;
  localparam int SEC_W = 4;
  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint TENTH_SEC_NS = 100000000;
  localparam longint TENTH_SEC_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam logic [SEC_W-1:0] TENTHS_PER_SEC = 4'ha;
  // ****************************************
  // voltage ranges, 0.1 v units
  // ****************************************
  localparam logic [VOLT_W-1:0] OV_MIN_LOW_CLASS = 14'hce4;
  localparam logic [VOLT_W-1:0] OV_MAX_LOW_CLASS = 14'h1004;
  localparam logic [VOLT_W-1:0] OV_MIN_HIGH_CLASS = 14'h19c8;
  localparam logic [VOLT_W-1:0] OV_MAX_HIGH_CLASS = 14'h2008;
  // ****************************************
  // percent of rated output current
  // ****************************************
  localparam logic [CUR_W-1:0] RATED_PCT = 10'h064;
  localparam logic [CUR_W-1:0] STD_MOTOR_PCT = 10'h05a;
  localparam logic [ACC_W-1:0] TRIP_SQ_MARGIN = 32'h1388;
  // ****************************************
  // mode encodings
  // ****************************************
  localparam logic [2:0] OT_OFF = 3'h0;
  localparam logic [2:0] OT_CONST_RUN = 3'h1;
  localparam logic [2:0] OT_CONST_STOP = 3'h2;
  localparam logic [2:0] OT_ACC_RUN = 3'h3;
  localparam logic [2:0] OT_ACC_STOP = 3'h4;
  localparam logic [1:0] TH_STD = 2'h0;
  localparam logic [1:0] TH_SPECIAL = 2'h1;
  localparam logic [1:0] TH_OFF = 2'h2;
  localparam logic [7:0] MFO_OVER_TORQUE = 8'h04;
  // ****************************************
  // fault codes
  // ****************************************
  localparam logic [CODE_W-1:0] FC_NONE = 6'h00;
  localparam logic [CODE_W-1:0] FC_OVERCURRENT = 6'h01;
  localparam logic [CODE_W-1:0] FC_OVERVOLTAGE = 6'h02;
  localparam logic [CODE_W-1:0] FC_SWITCH_HOT = 6'h03;
  localparam logic [CODE_W-1:0] FC_BOARD_HOT = 6'h04;
  localparam logic [CODE_W-1:0] FC_DRIVE_OVERLOAD = 6'h05;
  localparam logic [CODE_W-1:0] FC_THERMAL = 6'h06;
  localparam logic [CODE_W-1:0] FC_OVER_TORQUE = 6'h07;
  localparam logic [CODE_W-1:0] FC_EXTERNAL = 6'h08;
  localparam logic [CODE_W-1:0] FC_HW_PROTECT = 6'h09;
  localparam logic [CODE_W-1:0] FC_DBL_ACCEL = 6'h0a;
  localparam logic [CODE_W-1:0] FC_DBL_DECEL = 6'h0b;
  localparam logic [CODE_W-1:0] FC_DBL_STEADY = 6'h0c;
  localparam logic [CODE_W-1:0] FC_PHASE_LOSS = 6'h0e;
  localparam logic [CODE_W-1:0] FC_AUTO_RAMP = 6'h10;
  localparam logic [CODE_W-1:0] FC_SW_PROTECT = 6'h11;
  localparam logic [CODE_W-1:0] FC_PWR_CPU_WR = 6'h12;
  localparam logic [CODE_W-1:0] FC_PWR_CPU_RD = 6'h13;
  localparam logic [CODE_W-1:0] FC_HPF_CC_OC = 6'h14;
  localparam logic [CODE_W-1:0] FC_HPF_OV = 6'h15;
  localparam logic [CODE_W-1:0] FC_HPF_GND = 6'h16;
  localparam logic [CODE_W-1:0] FC_HPF_OC = 6'h17;
  localparam logic [CODE_W-1:0] FC_CHK_U = 6'h18;
  localparam logic [CODE_W-1:0] FC_CHK_V = 6'h19;
  localparam logic [CODE_W-1:0] FC_CHK_W = 6'h1a;
  localparam logic [CODE_W-1:0] FC_CHK_DCBUS = 6'h1b;
  localparam logic [CODE_W-1:0] FC_CHK_SWITCH = 6'h1c;
  localparam logic [CODE_W-1:0] FC_CHK_BOARD = 6'h1d;
  localparam logic [CODE_W-1:0] FC_CTL_CPU_WR = 6'h1e;
  localparam logic [CODE_W-1:0] FC_CTL_CPU_RD = 6'h1f;
  localparam logic [CODE_W-1:0] FC_ANALOG_IN = 6'h20;
  localparam logic [CODE_W-1:0] FC_THERMISTOR = 6'h22;
  localparam logic [CODE_W-1:0] FC_LINK_TIMEOUT = 6'h28;
  localparam logic [CODE_W-1:0] FC_MAX = 6'h28;
  // ****************************************
  // trip state
  // ****************************************
  typedef enum logic [1:0] {ST_RUN = 2'b01, ST_TRIP = 2'b10} dps_state_e;
endpackage : dps_pkg

// ==== core/dps_hist_if.sv ====
// carrier between supervisor and its fault history store
interface dps_hist_if;
  logic push;
  logic [dps_pkg::CODE_W-1:0] code;
  logic [dps_pkg::HIST_DEPTH-1:0][dps_pkg::CODE_W-1:0] rec;
  modport writer(output push, output code, input rec);
  modport store(input push, input code, output rec);
endinterface : dps_hist_if

// ==== core/dps_fault_hist.sv ====
// five-deep fault history, newest in slot 0
module dps_fault_hist (
  input wire logic ref_clk,
  input wire logic rst_n,
  dps_hist_if.store hist
);
  typedef struct packed {
    logic [dps_pkg::HIST_DEPTH-1:0][dps_pkg::CODE_W-1:0] rec;
  } dps_hist_s;

  dps_hist_s st_reg;
  dps_hist_s st_next;

  always_comb begin
    st_next = st_reg;
    if (hist.push) begin
      // oldest slot falls off the end
      for (int i = dps_pkg::HIST_DEPTH - 1; i > 0; i--) begin
        st_next.rec[i] = st_reg.rec[i-1];
      end
      st_next.rec[0] = hist.code;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hist.rec = st_reg.rec;

  shift_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hist.push |=> (hist.rec[1] == $past(hist.rec[0])) && (hist.rec[0] == $past(hist.code)))
    else $error("fault history did not shift on push");
endmodule : dps_fault_hist

// ==== verification/dps_ramp_model.sv ====
// ramp generator stand-in facing the supervisor
module dps_ramp_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] phase_cmd,
  input wire logic freq_hold,
  input wire logic freq_lower,
  output logic ramp_accel,
  output logic ramp_decel,
  output logic ramp_steady,
  output logic [15:0] freq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // phase and frequency
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_accel <= 1'b0;
      ramp_decel <= 1'b0;
      ramp_steady <= 1'b0;
      freq_out <= 16'h0000;
    end else begin
      ramp_accel <= (phase_cmd == 2'h1);
      ramp_steady <= (phase_cmd == 2'h2);
      ramp_decel <= (phase_cmd == 2'h3);
      // the ramp only moves when the supervisor lets it
      if (ramp_accel && !freq_hold) freq_out <= freq_out + 16'h0001;
      else if (ramp_decel && !freq_hold) freq_out <= freq_out - 16'h0001;
      else if (ramp_steady && freq_lower) freq_out <= freq_out - 16'h0001;
    end
  end
endmodule : dps_ramp_model

// ==== verification/drive_protection_supervisor_test.sv ====
// self-checking bench for the drive protection supervisor
module drive_protection_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and observation
  // ****************************************
  localparam logic [5:0] CODES [26] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h09,
    6'h0a, 6'h0b, 6'h0c, 6'h0e, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h17, 6'h18, 6'h1d,
    6'h1e, 6'h1f, 6'h20, 6'h22, 6'h28, 6'h00, 6'h29};
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic ramp_accel, ramp_decel, ramp_steady, freq_hold, freq_lower, over_torque_warning;
  logic over_torque_stop, thermal_overload_trip, drive_tripped, mfo_out;
  logic fault_event, reset_cmd;
  logic [1:0] phase_cmd, thermal_select;
  logic [2:0] over_torque_mode;
  logic [7:0] accel_stall_pct, run_stall_pct, over_torque_pct, mfo_function;
  logic [9:0] output_current_pct, over_torque_tenths, thermal_char_sec;
  logic [13:0] dc_bus_voltage, ov_stall_level;
  logic [5:0] fault_code;
  logic [15:0] freq_out, f;
  wire logic [4:0][5:0] rec;
  logic [4:0][5:0] hx;
  int n_errors = 0, n_checks = 0;

  always #10 ref_clk = ~ref_clk;

  dps_ramp_model far (.ref_clk(ref_clk), .rst_n(rst_n), .phase_cmd(phase_cmd),
    .freq_hold(freq_hold), .freq_lower(freq_lower), .ramp_accel(ramp_accel),
    .ramp_decel(ramp_decel), .ramp_steady(ramp_steady), .freq_out(freq_out));

  dps_supervisor #(.TENTH_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .ramp_accel(ramp_accel), .ramp_decel(ramp_decel), .ramp_steady(ramp_steady),
    .dc_bus_voltage(dc_bus_voltage), .output_current_pct(output_current_pct),
    .ov_stall_level(ov_stall_level), .accel_stall_pct(accel_stall_pct),
    .run_stall_pct(run_stall_pct), .over_torque_mode(over_torque_mode),
    .over_torque_pct(over_torque_pct), .over_torque_tenths(over_torque_tenths),
    .thermal_select(thermal_select), .thermal_char_sec(thermal_char_sec),
    .mfo_function(mfo_function), .fault_event(fault_event), .fault_code(fault_code),
    .reset_cmd(reset_cmd), .freq_hold(freq_hold), .freq_lower(freq_lower),
    .over_torque_warning(over_torque_warning), .over_torque_stop(over_torque_stop),
    .thermal_overload_trip(thermal_overload_trip), .drive_tripped(drive_tripped),
    .mfo_out(mfo_out), .fault_rec_0(rec[0]), .fault_rec_1(rec[1]), .fault_rec_2(rec[2]),
    .fault_rec_3(rec[3]), .fault_rec_4(rec[4]));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_val

  task automatic push_exp(input logic [5:0] c);
    hx = {hx[3:0], c};
  endtask : push_exp

  task automatic chk_hist();
    settle(2);
    for (int i = 0; i < 5; i++) chk_val(16'(rec[i]), 16'(hx[i]), "record");
  endtask : chk_hist

  // operator clears the trip once the cause is gone
  task automatic op_reset();
    @(posedge ref_clk);
    reset_cmd <= 1'b1;
    settle(8);
    chk_bit(drive_tripped, 1'b0, "trip clear");
    chk_bit(over_torque_stop, 1'b0, "stop clear");
    chk_bit(thermal_overload_trip, 1'b0, "thermal clear");
    @(posedge ref_clk);
    reset_cmd <= 1'b0;
    settle(4);
  endtask : op_reset
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_stall();
    @(posedge ref_clk);
    phase_cmd <= 2'h1;
    accel_stall_pct <= 8'haa;
    output_current_pct <= 10'h0aa;
    settle(20);
    chk_bit(freq_hold, 1'b0, "at level");
    @(posedge ref_clk);
    output_current_pct <= 10'h0ab;
    settle(2);
    f = freq_out;
    chk_bit(freq_hold, 1'b1, "accel hold");
    settle(3);
    chk_val(freq_out, f, "accel frozen");
    @(posedge ref_clk);
    accel_stall_pct <= 8'h00;
    settle(2);
    chk_bit(freq_hold, 1'b0, "accel off");
    @(posedge ref_clk);
    phase_cmd <= 2'h3;
    output_current_pct <= 10'h032;
    dc_bus_voltage <= 14'hf3d;
    settle(3);
    f = freq_out;
    chk_bit(freq_hold, 1'b1, "decel hold");
    settle(3);
    chk_val(freq_out, f, "decel frozen");
    @(posedge ref_clk);
    dc_bus_voltage <= 14'hf3c;
    settle(2);
    chk_bit(freq_hold, 1'b0, "decel resume");
    @(posedge ref_clk);
    dc_bus_voltage <= 14'h1f40;
    ov_stall_level <= 14'h0000;
    settle(2);
    chk_bit(freq_hold, 1'b0, "ov off");
    @(posedge ref_clk);
    phase_cmd <= 2'h2;
    output_current_pct <= 10'h0ab;
    settle(3);
    f = freq_out;
    chk_bit(freq_lower, 1'b1, "run lower");
    settle(3);
    chk_val(freq_out, f - 16'h0003, "run falls");
    @(posedge ref_clk);
    output_current_pct <= 10'h064;
    settle(2);
    chk_bit(freq_lower, 1'b0, "run resume");
    @(posedge ref_clk);
    run_stall_pct <= 8'h00;
    output_current_pct <= 10'h0c8;
    settle(2);
    chk_bit(freq_lower, 1'b0, "run off");
    $display("stall test done");
  endtask : t_stall

  task automatic t_torque();
    int n;
    logic [1:0] good;
    logic stp;
    for (int m = 0; m < 5; m++) begin
      good = (m >= 3) ? 2'h1 : 2'h2;
      stp = (m == 2 || m == 4);
      @(posedge ref_clk);
      over_torque_mode <= 3'(m);
      mfo_function <= (m == 3) ? 8'h05 : 8'h04;
      phase_cmd <= 2'h3 - good;
      output_current_pct <= 10'h0a0;
      settle(40);
      chk_bit(over_torque_warning, 1'b0, "off window");
      @(posedge ref_clk);
      phase_cmd <= good;
      settle(30);
      chk_bit(over_torque_warning, 1'b0, "too early");
      n = 0;
      while (over_torque_warning !== (m != 0) && n < 20) begin
        settle(1);
        n++;
      end
      chk_bit(over_torque_warning, m != 0, "warn");
      chk_bit(mfo_out, m == 1 || m == 2 || m == 4, "terminal");
      chk_bit(over_torque_stop, stp, "stop");
      if (stp) begin
        push_exp(dps_pkg::FC_OVER_TORQUE);
        chk_hist();
        chk_bit(drive_tripped, 1'b1, "torque trip");
      end
      @(posedge ref_clk);
      output_current_pct <= 10'h096;
      settle(2);
      chk_bit(over_torque_warning, 1'b0, "release");
      if (stp) op_reset();
    end
    $display("torque test done");
  endtask : t_torque

  task automatic t_thermal();
    int n;
    @(posedge ref_clk);
    phase_cmd <= 2'h2;
    over_torque_mode <= 3'h0;
    thermal_char_sec <= 10'h01e;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk);
      thermal_select <= 2'(s);
      output_current_pct <= 10'h0fa;
      settle(150);
      chk_bit(thermal_overload_trip, 1'b0, "early");
      n = 0;
      while (thermal_overload_trip !== (s != 2) && n < 400) begin
        settle(1);
        n++;
      end
      chk_bit(thermal_overload_trip, s != 2, "thermal");
      @(posedge ref_clk);
      output_current_pct <= 10'h032;
      if (s != 2) begin
        push_exp(dps_pkg::FC_THERMAL);
        chk_hist();
        op_reset();
      end
    end
    $display("thermal test done");
  endtask : t_thermal

  task automatic t_faults();
    for (int i = 0; i < 26; i++) begin
      @(posedge ref_clk);
      fault_event <= 1'b1;
      fault_code <= CODES[i];
      @(posedge ref_clk);
      fault_event <= 1'b0;
      if (CODES[i] != 6'h00 && CODES[i] <= 6'h28) push_exp(CODES[i]);
      chk_hist();
    end
    chk_bit(drive_tripped, 1'b1, "fault trip");
    op_reset();
    chk_hist();
    $display("fault test done");
  endtask : t_faults
  // ****************************************
  // run control
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  initial begin
    {phase_cmd, thermal_select, over_torque_mode, fault_event, reset_cmd} = '0;
    {dc_bus_voltage, output_current_pct, fault_code, hx} = '0;
    ov_stall_level = 14'hf3c;
    {accel_stall_pct, run_stall_pct} = {8'haa, 8'haa};
    {over_torque_pct, over_torque_tenths, mfo_function} = {8'h96, 10'h003, 8'h04};
    {thermal_select, thermal_char_sec} = {2'h2, 10'h03c};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(1);
    chk_bit(drive_tripped, 1'b0, "reset idle");
    chk_hist();
    t_stall();
    t_torque();
    t_thermal();
    t_faults();
    final_report();
  end

  // the tests need well under 10000 cycles
  initial begin
    #400000;
    $display("MISMATCH t=%0t watchdog expired", $time);
    n_errors++;
    final_report();
  end
endmodule : drive_protection_supervisor_test
